// *** logic/rtcts_map.vh ***
// register offsets, field positions and reset values of the capture unit
`ifndef RTCTS_MAP_VH
`define RTCTS_MAP_VH
`define RTCTS_IDX_CTL2      8'h01
`define RTCTS_IDX_CAPCTL    8'h12
`define RTCTS_IDX_SEC       8'h13
`define RTCTS_IDX_MIN       8'h14
`define RTCTS_IDX_HOUR      8'h15
`define RTCTS_IDX_DAY       8'h16
`define RTCTS_IDX_MON       8'h17
`define RTCTS_IDX_YEAR      8'h18
`define RTCTS_IDX_IRQ_STAT  8'h20
`define RTCTS_IDX_IRQ_EN    8'h21
`define RTCTS_IDX_IRQ_CLR   8'h22
`define RTCTS_IDX_CONFIG    8'h23
`define RTCTS_BIT_COUNTDOWN_FLAG      3
`define RTCTS_BIT_AF        4
`define RTCTS_BIT_CAPTURE_FLAG_GROUND      5
`define RTCTS_BIT_WATCHDOG_FLAG      6
`define RTCTS_BIT_MSF       7
`define RTCTS_BIT_KEEP1ST   7
`define RTCTS_BIT_OFF       6
`define RTCTS_BIT_CAPTURE_FLAG_ANY      0
`define RTCTS_BIT_CAPTURE_IRQ_ENABLE      1
`define RTCTS_BIT_H12       2
`define RTCTS_CTL_RESET     8'h00
`define RTCTS_IRQ_W         4
`endif

// *** logic/rtcts_sync.v ***
// two-flop synchroniser with single-pulse edge detect for one level
`timescale 1ns/1ps
module rtcts_sync
(
    input  wire hclk,
    input  wire hresetn,
    input  wire din,
    output reg  level_r,
    output reg  rise_r
);
    reg meta_r;   // first stage, read only by level_r
    reg prev_r;   // last synchronised level

    // metastability guard then edge detect on the clean stage
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r  <= 1'b0;
            level_r <= 1'b0;
            prev_r  <= 1'b0;
            rise_r  <= 1'b0;
        end
        else
        begin
            meta_r  <= din;
            level_r <= meta_r;
            prev_r  <= level_r;
            rise_r  <= level_r & ~prev_r; // one pulse per assertion
        end
    end
endmodule

// *** logic/rtcts_top.v ***
// timestamp capture unit of the rtc with ahb-lite register slave
// Notes on behaviour
// - classify input: intermediate level or ground
// - capture on after reset; disable bit stops
// - intermediate event: snapshot, set flag one
// - flag one clears; resets only on fresh edge
// - ground event: snapshot, set both flags
// - irq drops once both flags cleared
// - mode zero overwrites, mode one keeps first
// - flags at bits 3,4,7 clear each on its own
// - sixteenths bcd in capture control low bits
// - seconds bcd at 13h
// - minutes bcd at 14h
// - hour follows 12/24 mode with pm bit
// - day bcd at 16h
// - flag writes are bitwise and
// - watchdog flag ignores writes
// - month and year captured too
`timescale 1ns/1ps
`include "rtcts_map.vh"
module rtcts_top
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        det_mid,
    input  wire        det_gnd,
    input  wire [3:0]  now_sub16,
    input  wire [6:0]  now_sec,
    input  wire [6:0]  now_min,
    input  wire [5:0]  now_hour,
    input  wire [5:0]  now_day,
    input  wire [4:0]  now_mon,
    input  wire [7:0]  now_year,
    input  wire        tick_stable,
    input  wire        set_countdown_flag,
    input  wire        set_af,
    input  wire        set_msf,
    input  wire        watchdog_flag_in,
    output reg         irq_r,
    output reg         ts_irq_r
);
    // address phase registers
    reg        wr_pend_r;   // write data phase due
    reg [7:0]  wr_idx_r;    // word index of pending write
    // control and flag state
    reg        keep_first_r;  // capture_keep_first
    reg        cap_off_r;     // capture_disable
    reg        irq_en_r;      // capture_irq_enable
    reg        h12_r;         // clock in 12 hour mode
    reg        capture_flag_any_r;        // capture_flag_any
    reg        capture_flag_ground_r;        // capture_flag_ground
    reg        countdown_flag_r;        // countdown_flag
    reg        af_r;          // alarm_flag
    reg        msf_r;         // minsec_flag
    // snapshot storage
    reg [4:0]  cap_sub_r;
    reg [6:0]  cap_sec_r;
    reg [6:0]  cap_min_r;
    reg [5:0]  cap_hour_r;
    reg [5:0]  cap_day_r;
    reg [4:0]  cap_mon_r;
    reg [7:0]  cap_year_r;
    // pending capture waits for a stable counter instant
    reg        cap_pend_r;
    // generic interrupt block
    reg [3:0]  irq_stat_r;   // sticky events
    reg [3:0]  irq_mask_r;   // enable mask
    wire       mid_lvl;
    wire       mid_rise;
    wire       gnd_lvl;
    wire       gnd_rise;
    wire       ev_mid;       // intermediate event this cycle
    wire       ev_gnd;       // ground event this cycle
    wire       ev_any;
    wire       flags_set;
    wire       take_snap;
    wire       addr_ok;
    wire       wr_ctl2;
    wire       wr_capctl;
    wire [7:0] wd8;
    reg  [31:0] rd_nxt;

    // low byte of write data, narrow registers sit in low bits
    assign wd8 = hwdata[7:0];

    // detector outputs brought into hclk, one pulse per assertion
    rtcts_sync u_mid
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (det_mid),
        .level_r (mid_lvl),
        .rise_r  (mid_rise)
    );
    rtcts_sync u_gnd
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (det_gnd),
        .level_r (gnd_lvl),
        .rise_r  (gnd_rise)
    );

    // a ground drive trips the mid level in the same cycle or later; both count
    // as one ground event so the snapshot is not taken twice
    assign ev_gnd = gnd_rise & ~cap_off_r;
    assign ev_mid = mid_rise & ~gnd_lvl & ~cap_off_r;
    assign ev_any = ev_mid | ev_gnd;
    assign flags_set = capture_flag_any_r | capture_flag_ground_r;
    // keep-first mode leaves the first event untouched
    assign take_snap = ev_any & ~(keep_first_r & flags_set);

    // bus decode helpers
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_ctl2 = wr_pend_r & (wr_idx_r == `RTCTS_IDX_CTL2);
    assign wr_capctl = wr_pend_r & (wr_idx_r == `RTCTS_IDX_CAPCTL);

    // converts a 24 hour bcd value to 12 hour form with pm bit
    function [5:0] to_h12;
        input [5:0] h;
        reg   [4:0] bin;
        reg   [4:0] b12;
        begin
            bin = h[5:4] * 5'd10 + {1'b0, h[3:0]};
            b12 = (bin == 5'd0) ? 5'd12 :
                  (bin > 5'd12) ? bin - 5'd12 : bin;
            to_h12 = {(bin >= 5'd12), (b12 >= 5'd10),
                      (b12 >= 5'd10) ? b12[3:0] - 4'hA : b12[3:0]};
        end
    endfunction

    // ahb address phase capture; slave is always zero wait
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend_r <= addr_ok & hwrite;
            wr_idx_r  <= haddr[9:2];
            hreadyout <= 1'b1;
            hresp     <= 1'b0; // always okay
        end
    end

    // read mux, registered so data stands in the data phase
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        case (haddr[9:2])
            `RTCTS_IDX_CTL2:
                rd_nxt[7:0] = {msf_r, watchdog_flag_in, capture_flag_ground_r, af_r, countdown_flag_r,
                               3'b000};
            `RTCTS_IDX_CAPCTL:
                rd_nxt[7:0] = {keep_first_r, cap_off_r, 1'b0,
                               cap_sub_r};
            `RTCTS_IDX_SEC:  rd_nxt[7:0] = {1'b0, cap_sec_r};
            `RTCTS_IDX_MIN:  rd_nxt[7:0] = {1'b0, cap_min_r};
            `RTCTS_IDX_HOUR: rd_nxt[7:0] = {2'b00, cap_hour_r};
            `RTCTS_IDX_DAY:  rd_nxt[7:0] = {2'b00, cap_day_r};
            `RTCTS_IDX_MON:  rd_nxt[7:0] = {3'b000, cap_mon_r};
            `RTCTS_IDX_YEAR: rd_nxt[7:0] = cap_year_r;
            `RTCTS_IDX_IRQ_STAT: rd_nxt[3:0] = irq_stat_r;
            `RTCTS_IDX_IRQ_EN:   rd_nxt[3:0] = irq_mask_r;
            `RTCTS_IDX_CONFIG:
                rd_nxt[2:0] = {h12_r, irq_en_r, capture_flag_any_r};
            default: rd_nxt = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // read data register
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok & ~hwrite)
            hrdata <= rd_nxt;
    end

    // control bits written by software
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            keep_first_r <= 1'b0;
            cap_off_r    <= 1'b0;
            irq_en_r     <= 1'b0;
            h12_r        <= 1'b0;
            irq_mask_r   <= 4'h0;
        end
        else if (wr_pend_r)
        begin
            if (wr_capctl)
            begin
                keep_first_r <= wd8[`RTCTS_BIT_KEEP1ST];
                cap_off_r    <= wd8[`RTCTS_BIT_OFF];
            end
            if (wr_idx_r == `RTCTS_IDX_CONFIG)
            begin
                irq_en_r <= wd8[`RTCTS_BIT_CAPTURE_IRQ_ENABLE];
                h12_r    <= wd8[`RTCTS_BIT_H12];
            end
            if (wr_idx_r == `RTCTS_IDX_IRQ_EN)
                irq_mask_r <= wd8[3:0];
        end
    end

    // flags: writes and, hardware set wins over a clear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            capture_flag_any_r <= 1'b0;
            capture_flag_ground_r <= 1'b0;
            countdown_flag_r <= 1'b0;
            af_r   <= 1'b0;
            msf_r  <= 1'b0;
        end
        else
        begin
            // watchdog_flag bit of the write is simply not used
            countdown_flag_r <= set_countdown_flag | (countdown_flag_r &
                      ~(wr_ctl2 & ~wd8[`RTCTS_BIT_COUNTDOWN_FLAG]));
            af_r   <= set_af | (af_r &
                      ~(wr_ctl2 & ~wd8[`RTCTS_BIT_AF]));
            msf_r  <= set_msf | (msf_r &
                      ~(wr_ctl2 & ~wd8[`RTCTS_BIT_MSF]));
            capture_flag_ground_r <= ev_gnd | (capture_flag_ground_r &
                      ~(wr_ctl2 & ~wd8[`RTCTS_BIT_CAPTURE_FLAG_GROUND]));
            // flag one clears in the config register by writing zero
            capture_flag_any_r <= ev_any | (capture_flag_any_r &
                      ~((wr_idx_r == `RTCTS_IDX_CONFIG) & wr_pend_r &
                        ~wd8[`RTCTS_BIT_CAPTURE_FLAG_ANY]));
        end
    end

    // snapshot waits while counters ripple so all fields agree
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cap_pend_r <= 1'b0;
        else if (take_snap & ~tick_stable)
            cap_pend_r <= 1'b1;
        else if (tick_stable)
            cap_pend_r <= 1'b0;
    end

    // snapshot registers, loaded together in one edge
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_sub_r  <= 5'h00;
            cap_sec_r  <= 7'h00;
            cap_min_r  <= 7'h00;
            cap_hour_r <= 6'h00;
            cap_day_r  <= 6'h00;
            cap_mon_r  <= 5'h00;
            cap_year_r <= 8'h00;
        end
        else if ((take_snap | cap_pend_r) & tick_stable)
        begin
            // sixteenths 0..15 as two digit bcd
            cap_sub_r  <= (now_sub16 >= 4'hA) ?
                          {1'b1, now_sub16 - 4'hA} :
                          {1'b0, now_sub16};
            cap_sec_r  <= now_sec;
            cap_min_r  <= now_min;
            cap_hour_r <= h12_r ? to_h12(now_hour) : now_hour;
            cap_day_r  <= now_day;
            cap_mon_r  <= now_mon;
            cap_year_r <= now_year;
        end
    end

    // sticky status: bit0 mid event, bit1 ground, bit2 cleared-off
    // overflow (event ignored in keep-first), bit3 disabled event
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat_r <= 4'h0;
        else
            irq_stat_r <= {mid_rise & cap_off_r,
                           ev_any & ~take_snap, ev_gnd, ev_mid} |
                          (irq_stat_r &
                           ~((wr_pend_r &
                              (wr_idx_r == `RTCTS_IDX_IRQ_CLR)) ?
                             wd8[3:0] : 4'h0));
    end

    // interrupt outputs, levels from flops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_r    <= 1'b0;
            ts_irq_r <= 1'b0;
        end
        else
        begin
            irq_r    <= |(irq_stat_r & irq_mask_r);
            // held until both capture flags cleared
            ts_irq_r <= irq_en_r & flags_set;
        end
    end
endmodule

// *** testbench/rtcts_properties.sv ***
// port assertions for the timestamp capture unit
`timescale 1ns/1ps
module rtcts_properties
(
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        det_mid,
    input wire        det_gnd,
    input wire        irq_r,
    input wire        ts_irq_r
);
    // accepted address phases
    wire tk = hsel & hready & htrans[1];
    wire rd = tk & ~hwrite;
    wire wr = tk & hwrite;
    // either detector, a possible cause of a capture
    wire det = det_mid | det_gnd;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    zero_wait_a: assert property (hreadyout)
        else $error("wait state inserted");
    okay_resp_a: assert property (!hresp)
        else $error("error response");
    read_hold_a: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    byte_lane_a: assert property (rd |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (rd && haddr[9:2] == 8'hFF
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    // a sticky capture interrupt only drops after a write
    ts_irq_hold_a: assert property (ts_irq_r && !wr && !$past(wr)
        && !$past(wr, 2) |=> ts_irq_r) else $error("capture irq lost");
    irq_hold_a: assert property (irq_r && !wr && !$past(wr)
        && !$past(wr, 2) |=> irq_r) else $error("irq lost");
    ts_irq_cause_a: assert property ($rose(ts_irq_r) |->
        $past(wr, 2) || $past(wr, 3) || $past(det, 4) || $past(det, 5))
        else $error("capture irq without cause");
endmodule
bind rtcts_top rtcts_properties u_rtcts_properties (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .det_mid, .det_gnd, .irq_r, .ts_irq_r);

// *** testbench/rtcts_tamper.sv ***
// tamper sensor model: pin level to the two detector outputs
`timescale 1ns/1ps
module rtcts_tamper
(
    input  wire       hclk,
    input  wire [1:0] lvl,
    output reg        det_mid = 1'b0,
    output reg        det_gnd = 1'b0
);
    // 0 open, 1 intermediate, 2 ground; ground also trips mid
    always @(posedge hclk)
    begin
        det_mid <= (lvl != 2'd0);
        det_gnd <= (lvl == 2'd2);
    end
endmodule

// *** testbench/rtcts_top_tb.sv ***
// self-checking bench for the timestamp capture unit
`timescale 1ns/1ps
`include "rtcts_map.vh"
module rtcts_top_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0]  htrans = 2'h0, lvl = 2'd0;
    logic        hwrite = 1'b0;
    logic        hreadyout, hresp, det_mid, det_gnd, irq_r, ts_irq_r;
    // live time fed to the snapshot
    logic [3:0]  now_sub16 = 4'hB;
    logic [6:0]  now_sec = 7'h59, now_min = 7'h42;
    logic [5:0]  now_hour = 6'h15, now_day = 6'h31;
    logic [4:0]  now_mon = 5'h12;
    logic [7:0]  now_year = 8'h99;
    logic        set_countdown_flag = 0, set_af = 0, set_msf = 0, watchdog_flag_in = 0;
    logic        tick_stable = 1'b1; // low while counters carry
    int          err_count = 0, n_tests = 0;
    always #50 hclk = ~hclk;
    rtcts_top u_rtcts_top (.hclk, .hresetn, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .det_mid, .det_gnd, .now_sub16,
        .now_sec, .now_min, .now_hour, .now_day, .now_mon, .now_year,
        .tick_stable, .set_countdown_flag, .set_af, .set_msf, .watchdog_flag_in,
        .irq_r, .ts_irq_r);
    rtcts_tamper u_rtcts_tamper (.hclk, .lvl, .det_mid, .det_gnd);
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one single ahb transfer; read data lands in d
    task automatic bus(input logic w, input logic [7:0] ix,
        input logic [31:0] wd);
        haddr <= {22'h0, ix, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
        bus(1'b1, ix, wd);
    endtask
    task automatic rdc(input string n, input logic [7:0] ix, e);
        bus(1'b0, ix, 32'h0);
        cmp(n, {24'h0, e}, d);
    endtask
    // pin level change, then room for sync and flag update
    task automatic ev(input logic [1:0] l);
        lvl <= l;
        repeat (8) @(posedge hclk);
    endtask
    task automatic t_mid;
        wr(`RTCTS_IDX_IRQ_EN, 32'h1);
        wr(`RTCTS_IDX_CONFIG, 32'h2);
        ev(1);
        rdc("sub", `RTCTS_IDX_CAPCTL, 8'h11);
        rdc("sec", `RTCTS_IDX_SEC, 8'h59);
        rdc("min", `RTCTS_IDX_MIN, 8'h42);
        rdc("hr", `RTCTS_IDX_HOUR, 8'h15);
        rdc("day", `RTCTS_IDX_DAY, 8'h31);
        rdc("mon", `RTCTS_IDX_MON, 8'h12);
        rdc("yr", `RTCTS_IDX_YEAR, 8'h99);
        rdc("cfg", `RTCTS_IDX_CONFIG, 8'h03);
        cmp("tsirq", 1, ts_irq_r);
        cmp("irq", 1, irq_r);
        wr(`RTCTS_IDX_CONFIG, 32'h2);
        // pin still held: no fresh edge, flag stays clear
        repeat (8) @(posedge hclk);
        rdc("cfg", `RTCTS_IDX_CONFIG, 8'h02);
        cmp("tsirq", 0, ts_irq_r);
        ev(0);
    endtask
    task automatic t_gnd;
        wr(`RTCTS_IDX_IRQ_EN, 32'h0);
        wr(`RTCTS_IDX_CONFIG, 32'h6);
        ev(2);
        cmp("mask", 0, irq_r);
        rdc("hr12", `RTCTS_IDX_HOUR, 8'h23);
        rdc("ctl2", `RTCTS_IDX_CTL2, 8'h20);
        rdc("cfg", `RTCTS_IDX_CONFIG, 8'h07);
        wr(`RTCTS_IDX_CONFIG, 32'h6);
        rdc("cfg", `RTCTS_IDX_CONFIG, 8'h06);
        cmp("tsirq", 1, ts_irq_r);
        wr(`RTCTS_IDX_CTL2, 32'hDF);
        rdc("ctl2", `RTCTS_IDX_CTL2, 8'h00);
        cmp("tsirq", 0, ts_irq_r);
        wr(`RTCTS_IDX_IRQ_EN, 32'h2);
        rdc("en", `RTCTS_IDX_IRQ_EN, 8'h02);
        cmp("irq", 1, irq_r);
        wr(`RTCTS_IDX_IRQ_CLR, 32'hF);
        rdc("stat", `RTCTS_IDX_IRQ_STAT, 8'h00);
        cmp("irq", 0, irq_r);
        ev(0);
    endtask
    task automatic t_mode;
        wr(`RTCTS_IDX_CAPCTL, 32'h80);
        ev(1);
        ev(0);
        now_sec <= 7'h07;
        ev(1);
        ev(0);
        rdc("keep", `RTCTS_IDX_CAPCTL, 8'h91);
        rdc("sec", `RTCTS_IDX_SEC, 8'h59);
        rdc("stat", `RTCTS_IDX_IRQ_STAT, 8'h05);
        wr(`RTCTS_IDX_CAPCTL, 32'h0);
        now_sec <= 7'h33;
        tick_stable <= 1'b0;
        ev(1);
        rdc("hold", `RTCTS_IDX_SEC, 8'h59);
        tick_stable <= 1'b1;
        ev(0);
        rdc("sec", `RTCTS_IDX_SEC, 8'h33);
        wr(`RTCTS_IDX_CONFIG, 32'h2);
    endtask
    task automatic t_off;
        wr(`RTCTS_IDX_IRQ_CLR, 32'hF);
        wr(`RTCTS_IDX_CAPCTL, 32'h40);
        ev(1);
        ev(0);
        rdc("off", `RTCTS_IDX_CONFIG, 8'h02);
        rdc("stat", `RTCTS_IDX_IRQ_STAT, 8'h08);
        rdc("unmap", 8'hFF, 8'h00);
    endtask
    task automatic t_flags;
        watchdog_flag_in <= 1'b1;
        set_countdown_flag <= 1'b1;
        set_af <= 1'b1;
        set_msf <= 1'b1;
        @(posedge hclk);
        set_countdown_flag <= 1'b0;
        set_af <= 1'b0;
        set_msf <= 1'b0;
        rdc("fl", `RTCTS_IDX_CTL2, 8'hD8);
        wr(`RTCTS_IDX_CTL2, 32'hF7);
        rdc("fl", `RTCTS_IDX_CTL2, 8'hD0);
        wr(`RTCTS_IDX_CTL2, 32'h0);
        rdc("fl", `RTCTS_IDX_CTL2, 8'h40);
    endtask
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("rst", `RTCTS_IDX_CAPCTL, 8'h00);
        t_mid();
        t_gnd();
        t_mode();
        t_off();
        t_flags();
        close_out();
    end
    // hang guard, well beyond the few hundred cycles used
    initial
    begin
        #2000000;
        err_count++;
        close_out();
    end
endmodule
